// ---- rtl/csoc_defines.vh ----
`ifndef CSOC_DEFINES_VH
`define CSOC_DEFINES_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define CSOC_ADDR_CFG_EXT      5'h1e
`define CSOC_RST_CFG_EXT       16'h0833
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSOC_PTHR_LSB          0
`define CSOC_PTHR_MSB          3
`define CSOC_NTHR_LSB          4
`define CSOC_NTHR_MSB          7
`define CSOC_HOLD_BIT          8
`define CSOC_MODE_BIT          9
`define CSOC_BRAKE_BIT         10
`define CSOC_CUTDIS_BIT        11
`define CSOC_REFSRC_BIT        12
`define CSOC_NEGDIS_BIT        13
`define CSOC_AZ_LSB            14
`define CSOC_AZ_MSB            15
// ----------------------------------------
// auto-zero and fault trigger codes
// ----------------------------------------
`define CSOC_AZ_INT            2'b00
`define CSOC_AZ_OFF            2'b01
`define CSOC_AZ_EXT            2'b10
`define CSOC_AZ_EXT_CPG        2'b11
`define CSOC_TRIG_CNT8         2'b00
`define CSOC_TRIG_CNT16        2'b01
`define CSOC_TRIG_ALL          2'b10
`define CSOC_TRIG_NONE         2'b11
`define CSOC_CNT8              5'h08
`define CSOC_CNT16             5'h10
// ----------------------------------------
// filter times in ns and cycles at 8 ns
// ----------------------------------------
`define CSOC_CLK_NS            8
`define CSOC_FLT_2US_NS        2000
`define CSOC_FLT_2US_CYC       (`CSOC_FLT_2US_NS / `CSOC_CLK_NS)
`define CSOC_FLT_4US_CYC       (2 * `CSOC_FLT_2US_CYC)
`define CSOC_FLT_8US_CYC       (4 * `CSOC_FLT_2US_CYC)
`endif

// ---- rtl/csoc_filter.v ----
`timescale 1ns/1ps
`include "csoc_defines.vh"
// ----------------------------------------
// deglitch filter for one comparator event
// ----------------------------------------
module csoc_filter #(
  parameter CNT_W = 11
) (
  input  wire             core_clk,
  input  wire             sys_rst,
  input  wire             raw_in,
  input  wire             bypass,
  input  wire [1:0]       filter_sel,
  output wire             filt_out
);
  reg  [CNT_W-1:0] cnt_ff;
  reg  [CNT_W-1:0] nxt_cnt;
  reg              held_ff;
  reg  [CNT_W-1:0] limit;

  localparam [31:0] LIM_2US = `CSOC_FLT_2US_CYC;
  localparam [31:0] LIM_4US = `CSOC_FLT_4US_CYC;
  localparam [31:0] LIM_8US = `CSOC_FLT_8US_CYC;

  always @* begin
    case (filter_sel)
      2'b01:   limit = LIM_2US[CNT_W-1:0];
      2'b10:   limit = LIM_4US[CNT_W-1:0];
      2'b11:   limit = LIM_8US[CNT_W-1:0];
      default: limit = {CNT_W{1'b0}};
    endcase
  end

  always @* begin
    if (!raw_in) begin
      nxt_cnt = {CNT_W{1'b0}};
    end else if (cnt_ff != limit) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else begin
      nxt_cnt = cnt_ff;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_ff  <= {CNT_W{1'b0}};
      held_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      held_ff <= raw_in && (cnt_ff == limit);
    end
  end

  assign filt_out = (bypass || filter_sel == 2'b00) ? raw_in : held_ff;
endmodule // csoc_filter

// ---- rtl/csoc_config.v ----
`timescale 1ns/1ps
`include "csoc_defines.vh"
module csoc_config #(
  parameter ADDR_W = 5,
  parameter DATA_W = 16
) (
  input  wire              core_clk,
  input  wire              sys_rst,
  input  wire              reg_wr_en,
  input  wire              reg_rd_en,
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [DATA_W-1:0] reg_wdata,
  output reg  [DATA_W-1:0] reg_rdata,
  input  wire              pos_cmp_raw,
  input  wire              neg_cmp_raw,
  input  wire [1:0]        overcurrent_filter_time,
  input  wire [1:0]        overcurrent_fault_trigger,
  input  wire              fault_clear,
  output reg  [3:0]        overcurrent_pos_threshold,
  output reg  [3:0]        overcurrent_neg_threshold,
  output reg               sense_mode_rdson,
  output reg               sense_timing_low_side_gate,
  output reg               offset_ref_source,
  output reg               autozero_enable,
  output reg               autozero_ext_sync,
  output reg               autozero_pump_gate,
  output reg               pwm_cutoff,
  output reg               overcurrent_fault,
  output reg               brake_request
);
  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  reg  [15:0] cfg_ff;
  reg  [4:0]  evt_cnt_ff;
  reg  [4:0]  nxt_evt_cnt;
  reg         evt_prev_ff;
  reg         latch_ff;
  reg         nxt_latch;
  reg         trig;
  reg  [4:0]  evt_goal;

  wire        hold_sel  = cfg_ff[`CSOC_HOLD_BIT];
  wire        brake_en  = cfg_ff[`CSOC_BRAKE_BIT];
  wire        cut_dis   = cfg_ff[`CSOC_CUTDIS_BIT];
  wire        neg_dis   = cfg_ff[`CSOC_NEGDIS_BIT];
  wire [1:0]  az_cfg    = cfg_ff[`CSOC_AZ_MSB:`CSOC_AZ_LSB];
  wire        addr_hit  = (reg_addr == `CSOC_ADDR_CFG_EXT);
  wire        pos_filt;
  wire        neg_filt;
  wire        evt_now;
  wire        evt_rise;
  wire        latched_mode;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_ff <= `CSOC_RST_CFG_EXT;
    end else if (reg_wr_en && addr_hit) begin
      cfg_ff <= reg_wdata[15:0];
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= {DATA_W{1'b0}};
    end else if (reg_rd_en) begin
      reg_rdata <= addr_hit ? cfg_ff : {DATA_W{1'b0}};
    end
  end

  // ----------------------------------------
  // comparator filtering
  // ----------------------------------------
  csoc_filter u_pos_filter (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .raw_in     (pos_cmp_raw),
    .bypass     (~cut_dis),
    .filter_sel (overcurrent_filter_time),
    .filt_out   (pos_filt)
  );

  csoc_filter u_neg_filter (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .raw_in     (neg_cmp_raw),
    .bypass     (~cut_dis),
    .filter_sel (overcurrent_filter_time),
    .filt_out   (neg_filt)
  );

  assign evt_now      = pos_filt | (neg_filt & ~neg_dis);
  assign evt_rise     = evt_now & ~evt_prev_ff;
  assign latched_mode = hold_sel | brake_en;

  // ----------------------------------------
  // fault trigger
  // ----------------------------------------
  always @* begin
    case (overcurrent_fault_trigger)
      `CSOC_TRIG_CNT8:  evt_goal = `CSOC_CNT8;
      `CSOC_TRIG_CNT16: evt_goal = `CSOC_CNT16;
      default:          evt_goal = 5'h01;
    endcase
  end

  always @* begin
    nxt_evt_cnt = evt_cnt_ff;
    trig        = 1'b0;
    if (fault_clear) begin
      nxt_evt_cnt = 5'h00;
    end
    if (overcurrent_fault_trigger != `CSOC_TRIG_NONE && evt_rise) begin
      if ((nxt_evt_cnt + 5'h01) >= evt_goal) begin
        trig        = 1'b1;
        nxt_evt_cnt = 5'h00;
      end else begin
        nxt_evt_cnt = nxt_evt_cnt + 5'h01;
      end
    end
  end

  always @* begin
    nxt_latch = latch_ff;
    if (fault_clear || !latched_mode) begin
      nxt_latch = 1'b0;
    end
    if (trig && latched_mode) begin
      nxt_latch = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      evt_cnt_ff  <= 5'h00;
      evt_prev_ff <= 1'b0;
      latch_ff    <= 1'b0;
    end else begin
      evt_cnt_ff  <= nxt_evt_cnt;
      evt_prev_ff <= evt_now;
      latch_ff    <= nxt_latch;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      overcurrent_pos_threshold  <= 4'h0;
      overcurrent_neg_threshold  <= 4'h0;
      sense_mode_rdson           <= 1'b0;
      sense_timing_low_side_gate <= 1'b0;
      offset_ref_source          <= 1'b0;
      autozero_enable            <= 1'b0;
      autozero_ext_sync          <= 1'b0;
      autozero_pump_gate         <= 1'b0;
      pwm_cutoff                 <= 1'b0;
      overcurrent_fault          <= 1'b0;
      brake_request              <= 1'b0;
    end else begin
      overcurrent_pos_threshold  <= cfg_ff[`CSOC_PTHR_MSB:`CSOC_PTHR_LSB];
      overcurrent_neg_threshold  <= cfg_ff[`CSOC_NTHR_MSB:`CSOC_NTHR_LSB];
      sense_mode_rdson           <= cfg_ff[`CSOC_MODE_BIT];
      sense_timing_low_side_gate <= cfg_ff[`CSOC_MODE_BIT];
      offset_ref_source          <= cfg_ff[`CSOC_REFSRC_BIT];
      autozero_enable            <= (az_cfg != `CSOC_AZ_OFF);
      autozero_ext_sync          <= (az_cfg == `CSOC_AZ_EXT) || (az_cfg == `CSOC_AZ_EXT_CPG);
      autozero_pump_gate         <= (az_cfg == `CSOC_AZ_EXT_CPG);
      pwm_cutoff                 <= evt_now & ~cut_dis;
      overcurrent_fault          <= latched_mode ? nxt_latch : (trig | (evt_now & overcurrent_fault && overcurrent_fault_trigger != `CSOC_TRIG_NONE));
      brake_request              <= brake_en & nxt_latch;
    end
  end
endmodule // csoc_config

// ---- testbench/csoc_monitor.sv ----
`timescale 1ns/1ps
module csoc_monitor #(parameter ADDR_W = 5, parameter DATA_W = 16) (
  input logic              core_clk,
  input logic              sys_rst,
  input logic              reg_wr_en,
  input logic              reg_rd_en,
  input logic [ADDR_W-1:0] reg_addr,
  input logic [DATA_W-1:0] reg_wdata,
  input logic [DATA_W-1:0] reg_rdata,
  input logic              pos_cmp_raw,
  input logic              neg_cmp_raw,
  input logic              fault_clear,
  input logic [3:0]        overcurrent_pos_threshold,
  input logic [3:0]        overcurrent_neg_threshold,
  input logic              autozero_enable,
  input logic              pwm_cutoff,
  input logic              overcurrent_fault,
  input logic              brake_request
);
  logic [DATA_W-1:0] shd_ff;
  logic              up_ff;
  wire               calm = !pos_cmp_raw && !neg_cmp_raw;
  // shadow of the config word
  always @(posedge core_clk) begin
    up_ff <= !sys_rst;
    if (sys_rst) shd_ff <= 16'h0833;
    else if (reg_wr_en && reg_addr == 5'h1e) shd_ff <= reg_wdata;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_thr_copy: assert property (
    up_ff |-> {overcurrent_neg_threshold, overcurrent_pos_threshold} == $past(shd_ff[7:0])) else $error("thr copy");
  a_az_decode: assert property (
    up_ff |-> autozero_enable == ($past(shd_ff[15:14]) != 2'h1)) else $error("autozero decode");
  a_read_back: assert property (
    reg_rd_en |=> reg_rdata == ($past(reg_addr) == 5'h1e ? $past(shd_ff) : 16'h0000)) else $error("read data");
  a_trunc_on: assert property (
    (!shd_ff[11] && pos_cmp_raw) [*3] |-> pwm_cutoff) else $error("no cutoff");
  a_trunc_off: assert property (
    shd_ff[11] && $past(shd_ff[11]) && $past(shd_ff[11], 2) |-> !pwm_cutoff) else $error("cutoff while off");
  a_neg_masked: assert property (
    (shd_ff[13] && !pos_cmp_raw) [*3] |-> !pwm_cutoff) else $error("neg not masked");
  a_no_brake: assert property (
    (!shd_ff[10]) [*3] |-> !brake_request) else $error("brake while off");
  a_clear_fault: assert property (
    calm ##1 (calm && fault_clear && !shd_ff[11]) ##1 calm [*2] |-> !overcurrent_fault) else $error("clear");
  c_brake: cover property (brake_request);
  c_rd_other: cover property (reg_rd_en && reg_addr != 5'h1e);
  c_fault: cover property ($rose(overcurrent_fault));
endmodule // csoc_monitor
bind csoc_config csoc_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_mon (.core_clk, .sys_rst, .reg_wr_en,
  .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .pos_cmp_raw, .neg_cmp_raw, .fault_clear,
  .overcurrent_pos_threshold, .overcurrent_neg_threshold, .autozero_enable, .pwm_cutoff,
  .overcurrent_fault, .brake_request);

// ---- testbench/csoc_config_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module csoc_config_tb;
  logic        core_clk = 0, sys_rst = 1, wr = 0, rd = 0, pc = 0, nc = 0, fc = 0;
  logic [4:0]  addr = 0;
  logic [15:0] wd = 0, rdat;
  logic [1:0]  tr = 0, ft = 0;
  logic [3:0]  pt, nt;
  logic        sm, st, rs, ae, ax, ap, cut, flt, brk;
  int          errors = 0, n_tests = 0;
  always #4 core_clk = ~core_clk;
  csoc_config u_dut (.core_clk, .sys_rst, .reg_wr_en(wr), .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .pos_cmp_raw(pc), .neg_cmp_raw(nc), .overcurrent_filter_time(ft),
    .overcurrent_fault_trigger(tr), .fault_clear(fc), .overcurrent_pos_threshold(pt),
    .overcurrent_neg_threshold(nt), .sense_mode_rdson(sm), .sense_timing_low_side_gate(st),
    .offset_ref_source(rs), .autozero_enable(ae), .autozero_ext_sync(ax), .autozero_pump_gate(ap),
    .pwm_cutoff(cut), .overcurrent_fault(flt), .brake_request(brk));
  task automatic cyc(input int n); repeat (n) @(posedge core_clk); #1; endtask
  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    addr = a; wd = d; wr = 1; cyc(1); wr = 0; cyc(2);
  endtask
  task automatic rreg(input logic [4:0] a, input logic [15:0] e);
    addr = a; rd = 1; cyc(1); rd = 0; `CHK("read", e, rdat)
    cyc(1);
  endtask
  task automatic ev(input int n);
    repeat (n) begin pc = 1; cyc(1); pc = 0; cyc(1); end
    cyc(2);
  endtask
  task automatic clr; fc = 1; cyc(1); fc = 0; cyc(2); endtask
  task automatic t_reset;
    rreg(5'h1e, 16'h0833);
    `CHK("thr", 8'h33, {pt, nt})
    `CHK("az", 3'h4, {ae, ax, ap})
  endtask
  task automatic t_fields;
    logic [15:0] tbl [4] = '{16'h1a5c, 16'h68c3, 16'hb60f, 16'hf2f0};
    logic [15:0] d;
    logic [13:0] e;
    for (int i = 0; i < 4; i++) begin
      d = tbl[i];
      e = {d[3:0], d[7:4], d[9], d[9], d[12], d[15:14] != 2'h1, d[15], &d[15:14]};
      wreg(5'h1e, d);
      rreg(5'h1e, d);
      `CHK("fields", e, {pt, nt, sm, st, rs, ae, ax, ap})
    end
    wreg(5'h1d, 16'hffff);
    rreg(5'h1d, 16'h0000);
    rreg(5'h1e, 16'hf2f0);
  endtask
  task automatic t_cut;
    tr = 2'h2; wreg(5'h1e, 16'h0033);
    pc = 1; cyc(3); `CHK("cut", 2'h3, {cut, flt})
    pc = 0; cyc(3); `CHK("release", 2'h0, {cut, flt})
    nc = 1; cyc(3); `CHK("neg", 2'h3, {cut, flt})
    nc = 0; wreg(5'h1e, 16'h2033);
    nc = 1; cyc(3); `CHK("neg off", 2'h0, {cut, flt})
    nc = 0; wreg(5'h1e, 16'h0833);
    pc = 1; cyc(3); `CHK("no cut", 2'h1, {cut, flt})
    pc = 0; cyc(3);
  endtask
  task automatic t_count;
    wreg(5'h1e, 16'h0933); tr = 2'h0; clr;
    ev(7); `CHK("cnt8 early", 1'h0, flt)
    ev(1); `CHK("cnt8", 1'h1, flt)
    cyc(5); `CHK("held", 2'h2, {flt, brk})
    clr; `CHK("cleared", 1'h0, flt)
    tr = 2'h1;
    ev(15); `CHK("cnt16 early", 1'h0, flt)
    ev(1); `CHK("cnt16", 1'h1, flt)
    clr; tr = 2'h3;
    ev(20); `CHK("none", 1'h0, flt)
  endtask
  task automatic t_brake;
    tr = 2'h2; wreg(5'h1e, 16'h0433);
    ev(1); `CHK("brake", 2'h3, {flt, brk})
    clr; `CHK("unbrake", 2'h0, {flt, brk})
  endtask
  task automatic t_filter;
    tr = 2'h2; ft = 2'h1; wreg(5'h1e, 16'h0833);
    pc = 1; cyc(100); `CHK("filtered", 2'h0, {cut, flt})
    cyc(200); `CHK("filter pass", 2'h1, {cut, flt})
    pc = 0; cyc(3); `CHK("filter drop", 2'h0, {cut, flt})
    wreg(5'h1e, 16'h0033);
    pc = 1; cyc(3); `CHK("bypass", 2'h3, {cut, flt})
    pc = 0; cyc(3); ft = 2'h0;
  endtask
  task automatic t_rerst;
    wreg(5'h1e, 16'h5a5a);
    sys_rst = 1; cyc(2); sys_rst = 0;
    rreg(5'h1e, 16'h0833);
    `CHK("rerst thr", 8'h33, {pt, nt})
  endtask
  task automatic finish_test;
    $display("errors %0d of %0d checks", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    #1 sys_rst = 0;
    t_reset; t_fields; t_cut; t_count; t_brake; t_filter; t_rerst;
    finish_test;
  end
  initial begin #50000; errors++; finish_test; end
endmodule // csoc_config_tb
